// ==== pkg/upr_map.vh ====
/*
 Register offsets, field positions, reset values and mode codes for the UART
 protocol parameter register block.
 Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
*/
// Summary of operation
// - Baud divisor high byte is a read/write register.
// - Baud divisor low byte is a companion register.
// - Receive read returns oldest unread FIFO byte.
// - Transmit write appends byte to FIFO tail.
// - DMX: first parameter counts bytes before break.
// - DALI device: first parameter is idle delay.
// - DALI gear: first parameter is back frame delay.
// - LIN: first parameter low six bits are identifier.
// - Address mode: first parameter sent with ninth bit set.
// - DMX: second/third parameter bound receive slots.
// - DALI: second parameter is forward frame threshold.
// - LIN slave: second parameter is transmit byte count.
// - LIN slave: third parameter is receive byte count.
// - Address match when masked exclusive-or is zero.
// - LIN transmit sum includes identifier only with seed option.
// - Other modes: transmit sum all bytes when option set.
// - Receive sum follows same identifier inclusion rule.
`ifndef UPR_MAP_VH
`define UPR_MAP_VH

// Byte addresses of the registers
`define UPR_OFS_BAUD_LOW 8'h00
`define UPR_OFS_BAUD_HIGH 8'h04
`define UPR_OFS_RX_DATA 8'h08
`define UPR_OFS_TX_DATA 8'h0c
`define UPR_OFS_P1_HIGH 8'h10
`define UPR_OFS_P1_LOW 8'h14
`define UPR_OFS_P2_HIGH 8'h18
`define UPR_OFS_P2_LOW 8'h1c
`define UPR_OFS_P3_HIGH 8'h20
`define UPR_OFS_P3_LOW 8'h24
`define UPR_OFS_TX_SUM 8'h28
`define UPR_OFS_RX_SUM 8'h2c
`define UPR_OFS_CONTROL 8'h30

// Reset values
`define UPR_RST_BYTE 8'h00
`define UPR_RST_BIT 1'b0
`define UPR_RST_CONTROL 8'h00

// Control register fields
`define UPR_CTL_MODE_LSB 0
`define UPR_CTL_MODE_MSB 3
`define UPR_CTL_SEED_BIT 4
`define UPR_CTL_BAUD_HIGH_SPEED_SELECT_BIT 5
`define UPR_CTL_ON_BIT 7

// Protocol mode codes
`define UPR_MODE_ASYNC8 4'h0
`define UPR_MODE_ADDR 4'h4
`define UPR_MODE_DALI_GEAR 4'h8
`define UPR_MODE_DALI_DEV 4'h9
`define UPR_MODE_DMX 4'ha
`define UPR_MODE_LIN_SLAVE 4'hb
`define UPR_MODE_LIN_MASTER 4'hc

// Divisor ceilings in the DALI group
`define UPR_BRG_MAX_FAST 16'h7ffe
`define UPR_BRG_MAX_SLOW 16'h1ffe

`endif

// ==== verilog/upr_csum.v ====
/*
 Eight-bit wrapping checksum accumulator with software load.
 Assumes add and load are single-cycle strobes in the block clock domain.
*/
`timescale 1ns/1ns
module upr_csum (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Software load
   input wire load_i,
   input wire [7:0] load_val_i,
   // Byte to accumulate
   input wire add_i,
   input wire [7:0] add_val_i,
   // Result
   output wire [7:0] sum_o
);
   reg [7:0] sum_q;
   reg [7:0] sum_d;
   reg [7:0] base;

   // A byte in the same cycle as a load is added to the loaded value, not lost
   always @* begin
      base = load_i ? load_val_i : sum_q;
      sum_d = add_i ? base + add_val_i : base;
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sum_q <= 8'h00;
      end else begin
         sum_q <= sum_d;
      end
   end

   assign sum_o = sum_q;
endmodule // upr_csum

// ==== verilog/upr_pdec.v ====
/*
 Mode-dependent meaning of the three 9-bit protocol parameters.
 Assumes parameters and mode are stable register outputs; purely combinational.
*/
`timescale 1ns/1ns
`include "upr_map.vh"
module upr_pdec (
   // Mode and parameters
   input wire [3:0] mode_i,
   input wire [8:0] p1_i,
   input wire [8:0] p2_i,
   input wire [8:0] p3_i,
   input wire [7:0] rx_addr_i,
   // Decoded views, zero where the mode gives no meaning
   output wire lin_mode_o,
   output wire [8:0] dmx_count_o,
   output wire [8:0] dmx_first_o,
   output wire [8:0] dmx_last_o,
   output wire [8:0] dali_delay_o,
   output wire [8:0] dali_thresh_o,
   output wire [5:0] lin_pid_o,
   output wire [7:0] lin_tx_count_o,
   output wire [7:0] lin_rx_count_o,
   output wire [8:0] addr_tx_o,
   output wire addr_match_o
);
   function is_dali;
      input [3:0] m;
      is_dali = (m == `UPR_MODE_DALI_GEAR) || (m == `UPR_MODE_DALI_DEV);
   endfunction

   function is_lin;
      input [3:0] m;
      is_lin = (m == `UPR_MODE_LIN_SLAVE) || (m == `UPR_MODE_LIN_MASTER);
   endfunction

   wire dmx = (mode_i == `UPR_MODE_DMX);
   wire addr = (mode_i == `UPR_MODE_ADDR);
   wire lin_s = (mode_i == `UPR_MODE_LIN_SLAVE);

   assign lin_mode_o = is_lin(mode_i);
   // Gating keeps meaningless bits away from the line logic
   assign dmx_count_o = dmx ? p1_i : 9'h000;
   assign dmx_first_o = dmx ? p2_i : 9'h000;
   assign dmx_last_o = dmx ? p3_i : 9'h000;
   // Device and gear both read the first parameter as a half-bit delay
   assign dali_delay_o = is_dali(mode_i) ? p1_i : 9'h000;
   assign dali_thresh_o = is_dali(mode_i) ? p2_i : 9'h000;
   assign lin_pid_o = is_lin(mode_i) ? p1_i[5:0] : 6'h00;
   assign lin_tx_count_o = lin_s ? p2_i[7:0] : 8'h00;
   assign lin_rx_count_o = lin_s ? p3_i[7:0] : 8'h00;
   assign addr_tx_o = addr ? {1'b1, p1_i[7:0]} : 9'h000;
   assign addr_match_o = addr && (((rx_addr_i ^ p2_i[7:0]) & p3_i[7:0]) == 8'h00);
endmodule // upr_pdec

// ==== verilog/upr_top.v ====
/*
 UART protocol parameter registers: baud divisor, receive and transmit data
 ports, three protocol parameters, transmit and receive checksums and a control
 register, reached over an Avalon-MM slave with waitrequest.
 Assumes the FIFOs, shift registers and line logic sit outside and signal byte
 events as single-cycle strobes on CLOCK_I.
*/
`timescale 1ns/1ns
`include "upr_map.vh"
module upr_top (
   // Clock and reset
   input wire CLOCK_I,
   input wire RSTN_I,
   // Avalon-MM slave
   input wire [7:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   output wire [31:0] AVS_READDATA_O,
   output wire AVS_WAITREQUEST_O,
   // Receive FIFO head
   input wire [7:0] RX_HEAD_I,
   input wire RX_EMPTY_I,
   output wire RX_POP_O,
   // Transmit FIFO tail
   input wire TX_FULL_I,
   output wire TX_PUSH_O,
   output wire [7:0] TX_DATA_O,
   // Bytes moving on the line
   input wire TX_SHIFT_I,
   input wire [7:0] TX_SHIFT_BYTE_I,
   input wire TX_SHIFT_ID_I,
   input wire RX_DONE_I,
   input wire [7:0] RX_DONE_BYTE_I,
   input wire RX_DONE_ID_I,
   input wire [7:0] RX_ADDR_I,
   // Controls toward the UART core
   output wire UART_ON_O,
   output wire [3:0] MODE_O,
   output wire BAUD_HIGH_SPEED_SELECT_O,
   output wire CHECKSUM_SEED_OPTION_O,
   output wire [15:0] BAUD_DIVISOR_O,
   output wire BAUD_LIMIT_ERR_O,
   // Decoded protocol parameters
   output wire [8:0] DMX_COUNT_O,
   output wire [8:0] DMX_FIRST_O,
   output wire [8:0] DMX_LAST_O,
   output wire [8:0] DALI_DELAY_O,
   output wire [8:0] DALI_THRESH_O,
   output wire [5:0] LIN_PID_O,
   output wire [7:0] LIN_TX_COUNT_O,
   output wire [7:0] LIN_RX_COUNT_O,
   output wire [8:0] ADDR_TX_O,
   output wire ADDR_MATCH_O,
   // Checksums
   output wire [7:0] TX_SUM_O,
   output wire [7:0] RX_SUM_O
);

   // ------------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------------
   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n = rst_sync_q;

   always @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------------
   reg [7:0] baud_low_q;
   reg [7:0] baud_high_q;
   reg [7:0] tx_byte_q;
   reg [8:0] first_param_q;
   reg [8:0] second_param_q;
   reg [8:0] third_param_q;
   reg [7:0] control_q;
   reg tx_push_q;
   reg ack_q;
   reg [31:0] rdata_q;

   // ------------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------------
   // One wait state per access: the first cycle of a request latches the
   // read data, the second completes it. This keeps read data registered.
   wire req = AVS_READ_I | AVS_WRITE_I;
   wire done = req & ack_q;
   wire wr_done = AVS_WRITE_I & ack_q & AVS_BYTEENABLE_I[0];
   wire rd_done = AVS_READ_I & ack_q;

   assign AVS_WAITREQUEST_O = req & ~ack_q;
   assign AVS_READDATA_O = rdata_q;

   always @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      hit = (a == ofs);
   endfunction

   wire wr_baud_low = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_BAUD_LOW);
   wire wr_baud_high = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_BAUD_HIGH);
   wire wr_tx = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_TX_DATA);
   wire wr_p1h = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_P1_HIGH);
   wire wr_p1l = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_P1_LOW);
   wire wr_p2h = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_P2_HIGH);
   wire wr_p2l = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_P2_LOW);
   wire wr_p3h = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_P3_HIGH);
   wire wr_p3l = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_P3_LOW);
   wire wr_tx_sum = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_TX_SUM);
   wire wr_rx_sum = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_RX_SUM);
   wire wr_ctl = wr_done & hit(AVS_ADDRESS_I, `UPR_OFS_CONTROL);
   wire rd_rx = rd_done & hit(AVS_ADDRESS_I, `UPR_OFS_RX_DATA);

   // ------------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------------
   // Divisor writes are accepted even while on; software keeps it off
   // while changing them, otherwise the core may see a torn divisor.
   always @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         baud_low_q <= `UPR_RST_BYTE;
         baud_high_q <= `UPR_RST_BYTE;
         control_q <= `UPR_RST_CONTROL;
      end else begin
         if (wr_baud_low) begin
            baud_low_q <= AVS_WRITEDATA_I[7:0];
         end
         if (wr_baud_high) begin
            baud_high_q <= AVS_WRITEDATA_I[7:0];
         end
         if (wr_ctl) begin
            control_q <= AVS_WRITEDATA_I[7:0];
         end
      end
   end

   // Parameters are stored whole whatever the mode
   always @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         first_param_q <= {`UPR_RST_BIT, `UPR_RST_BYTE};
         second_param_q <= {`UPR_RST_BIT, `UPR_RST_BYTE};
         third_param_q <= {`UPR_RST_BIT, `UPR_RST_BYTE};
      end else begin
         if (wr_p1h) begin
            first_param_q[8] <= AVS_WRITEDATA_I[0];
         end
         if (wr_p1l) begin
            first_param_q[7:0] <= AVS_WRITEDATA_I[7:0];
         end
         if (wr_p2h) begin
            second_param_q[8] <= AVS_WRITEDATA_I[0];
         end
         if (wr_p2l) begin
            second_param_q[7:0] <= AVS_WRITEDATA_I[7:0];
         end
         if (wr_p3h) begin
            third_param_q[8] <= AVS_WRITEDATA_I[0];
         end
         if (wr_p3l) begin
            third_param_q[7:0] <= AVS_WRITEDATA_I[7:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Transmit and receive data ports
   // ------------------------------------------------------------------
   // A write while the FIFO is full is dropped; the byte still reads back.
   always @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte_q <= `UPR_RST_BYTE;
         tx_push_q <= 1'b0;
      end else begin
         if (wr_tx) begin
            tx_byte_q <= AVS_WRITEDATA_I[7:0];
         end
         tx_push_q <= wr_tx & ~TX_FULL_I;
      end
   end

   assign TX_PUSH_O = tx_push_q;
   assign TX_DATA_O = tx_byte_q;
   // The head byte was latched at the first edge; pop at completion
   assign RX_POP_O = rd_rx & ~RX_EMPTY_I;

   // ------------------------------------------------------------------
   // Checksums
   // ------------------------------------------------------------------
   wire lin_mode;
   wire seed = control_q[`UPR_CTL_SEED_BIT];
   wire [7:0] tx_sum;
   wire [7:0] rx_sum;
   // LIN: identifier only with the seed option; elsewhere all bytes or none
   wire tx_add = TX_SHIFT_I & (lin_mode ? (seed | ~TX_SHIFT_ID_I) : seed);
   wire rx_add = RX_DONE_I & (lin_mode ? (seed | ~RX_DONE_ID_I) : seed);

   upr_csum u_tx_sum (
      .clk_i(CLOCK_I),
      .rst_n_i(rst_n),
      .load_i(wr_tx_sum),
      .load_val_i(AVS_WRITEDATA_I[7:0]),
      .add_i(tx_add),
      .add_val_i(TX_SHIFT_BYTE_I),
      .sum_o(tx_sum)
   );

   upr_csum u_rx_sum (
      .clk_i(CLOCK_I),
      .rst_n_i(rst_n),
      .load_i(wr_rx_sum),
      .load_val_i(AVS_WRITEDATA_I[7:0]),
      .add_i(rx_add),
      .add_val_i(RX_DONE_BYTE_I),
      .sum_o(rx_sum)
   );

   assign TX_SUM_O = tx_sum;
   assign RX_SUM_O = rx_sum;

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   reg [7:0] rbyte;

   always @* begin
      rbyte = 8'h00;
      case (AVS_ADDRESS_I)
         `UPR_OFS_BAUD_LOW: begin
            rbyte = baud_low_q;
         end
         `UPR_OFS_BAUD_HIGH: begin
            rbyte = baud_high_q;
         end
         `UPR_OFS_RX_DATA: begin
            rbyte = RX_HEAD_I;
         end
         `UPR_OFS_TX_DATA: begin
            rbyte = tx_byte_q;
         end
         `UPR_OFS_P1_HIGH: begin
            rbyte = {7'h00, first_param_q[8]};
         end
         `UPR_OFS_P1_LOW: begin
            rbyte = first_param_q[7:0];
         end
         `UPR_OFS_P2_HIGH: begin
            rbyte = {7'h00, second_param_q[8]};
         end
         `UPR_OFS_P2_LOW: begin
            rbyte = second_param_q[7:0];
         end
         `UPR_OFS_P3_HIGH: begin
            rbyte = {7'h00, third_param_q[8]};
         end
         `UPR_OFS_P3_LOW: begin
            rbyte = third_param_q[7:0];
         end
         `UPR_OFS_TX_SUM: begin
            rbyte = tx_sum;
         end
         `UPR_OFS_RX_SUM: begin
            rbyte = rx_sum;
         end
         `UPR_OFS_CONTROL: begin
            rbyte = control_q;
         end
         default: begin
            rbyte = 8'h00;
         end
      endcase
   end

   always @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (AVS_READ_I & ~ack_q) begin
         rdata_q <= {24'h000000, rbyte};
      end
   end

   // ------------------------------------------------------------------
   // Controls and parameter decode
   // ------------------------------------------------------------------
   wire [3:0] mode = control_q[`UPR_CTL_MODE_MSB:`UPR_CTL_MODE_LSB];
   wire baud_high_speed_select = control_q[`UPR_CTL_BAUD_HIGH_SPEED_SELECT_BIT];
   wire [15:0] divisor = {baud_high_q, baud_low_q};
   wire [3:0] gear_code = `UPR_MODE_DALI_GEAR;
   wire dali_group = (mode[3:1] == gear_code[3:1]);

   assign UART_ON_O = control_q[`UPR_CTL_ON_BIT];
   assign MODE_O = mode;
   assign BAUD_HIGH_SPEED_SELECT_O = baud_high_speed_select;
   assign CHECKSUM_SEED_OPTION_O = seed;
   assign BAUD_DIVISOR_O = divisor;
   // Flags a divisor above the ceiling in the DALI group modes only; the core is free to ignore it
   assign BAUD_LIMIT_ERR_O = dali_group &
      (baud_high_speed_select ? (divisor > `UPR_BRG_MAX_FAST) : (divisor > `UPR_BRG_MAX_SLOW));

   upr_pdec u_pdec (
      .mode_i(mode),
      .p1_i(first_param_q),
      .p2_i(second_param_q),
      .p3_i(third_param_q),
      .rx_addr_i(RX_ADDR_I),
      .lin_mode_o(lin_mode),
      .dmx_count_o(DMX_COUNT_O),
      .dmx_first_o(DMX_FIRST_O),
      .dmx_last_o(DMX_LAST_O),
      .dali_delay_o(DALI_DELAY_O),
      .dali_thresh_o(DALI_THRESH_O),
      .lin_pid_o(LIN_PID_O),
      .lin_tx_count_o(LIN_TX_COUNT_O),
      .lin_rx_count_o(LIN_RX_COUNT_O),
      .addr_tx_o(ADDR_TX_O),
      .addr_match_o(ADDR_MATCH_O)
   );

endmodule // upr_top

// ==== tb/upr_fifo_model.sv ====
/*
 Behavioural receive and transmit FIFOs that sit beyond the parameter registers.
 Assumes pop and push are single-cycle strobes on the block clock.
*/
`timescale 1ns/1ns
module upr_fifo_model #(parameter int DEPTH = 2) (
   // Clock, reset and strobes
   input wire logic clk_i, rst_n_i, pop_i, push_i,
   input wire logic [7:0] push_data_i,
   // Head and flags
   output logic [7:0] head_o = 8'h00,
   output logic empty_o = 1'h1,
   output logic full_o = 1'h0
);
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   logic [7:0] last = 8'h00;
   task load(input logic [7:0] b);
      rxq.push_back(b);
   endtask
   always @(posedge clk_i) begin
      if (!rst_n_i) txq.delete();
      if (pop_i && rxq.size() > 0) last = rxq.pop_front();
      if (push_i && txq.size() < DEPTH) txq.push_back(push_data_i);
      empty_o <= (rxq.size() == 0);
      // An empty FIFO shows no stale byte, so a wrong pop cannot pass unseen
      head_o <= (rxq.size() > 0) ? rxq[0] : ~last;
      full_o <= (txq.size() >= DEPTH);
   end
endmodule // upr_fifo_model

// ==== tb/upr_checker.sv ====
/*
 Concurrent checks on the parameter register block ports.
 Assumes it is bound into upr_top and sees only its ports.
*/
`timescale 1ns/1ns
`include "upr_map.vh"
module upr_checker (
   // Clock, reset and bus
   input wire logic CLOCK_I, RSTN_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O,
   input wire logic [3:0] AVS_BYTEENABLE_I, MODE_O,
   // FIFO side, line events and controls
   input wire logic RX_EMPTY_I, RX_POP_O, TX_FULL_I, TX_PUSH_O, TX_SHIFT_I, TX_SHIFT_ID_I,
   input wire logic RX_DONE_I, RX_DONE_ID_I, CHECKSUM_SEED_OPTION_O,
   input wire logic BAUD_HIGH_SPEED_SELECT_O, BAUD_LIMIT_ERR_O,
   input wire logic [7:0] RX_HEAD_I, TX_DATA_O, TX_SHIFT_BYTE_I, RX_DONE_BYTE_I,
   input wire logic [7:0] TX_SUM_O, RX_SUM_O,
   input wire logic [15:0] BAUD_DIVISOR_O,
   input wire logic [8:0] DMX_COUNT_O, DALI_DELAY_O, ADDR_TX_O,
   input wire logic [5:0] LIN_PID_O
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   wire done_w = AVS_WRITE_I & ~AVS_WAITREQUEST_O & AVS_BYTEENABLE_I[0];
   wire rdone_w = AVS_READ_I & ~AVS_WAITREQUEST_O & (AVS_ADDRESS_I == `UPR_OFS_RX_DATA);
   wire lin_w = (MODE_O == `UPR_MODE_LIN_SLAVE) | (MODE_O == `UPR_MODE_LIN_MASTER);
   wire seed_w = CHECKSUM_SEED_OPTION_O;
   wire tx_add_w = TX_SHIFT_I & (lin_w ? (seed_w | ~TX_SHIFT_ID_I) : seed_w);
   wire rx_add_w = RX_DONE_I & (lin_w ? (seed_w | ~RX_DONE_ID_I) : seed_w);
   wire [7:0] tx_nx_w = TX_SUM_O + (tx_add_w ? TX_SHIFT_BYTE_I : 8'h00);
   wire [7:0] rx_nx_w = RX_SUM_O + (rx_add_w ? RX_DONE_BYTE_I : 8'h00);
   wire [7:0] wb_w = AVS_WRITEDATA_I[7:0];
   wire [15:0] lim_w = BAUD_HIGH_SPEED_SELECT_O ? `UPR_BRG_MAX_FAST : `UPR_BRG_MAX_SLOW;
   function automatic logic wa(input logic [7:0] a);
      return done_w && (AVS_ADDRESS_I == a);
   endfunction
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RSTN_I);
   sequence one_wait_s;
      AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   one_wait_a: assert property ($rose(AVS_READ_I | AVS_WRITE_I) |-> one_wait_s)
      else $error("bus request without exactly one wait state");
   baud_high_a: assert property (wa(`UPR_OFS_BAUD_HIGH) |=> BAUD_DIVISOR_O[15:8] == $past(wb_w))
      else $error("divisor high byte not taken");
   baud_low_a: assert property (wa(`UPR_OFS_BAUD_LOW) |=> BAUD_DIVISOR_O[7:0] == $past(wb_w))
      else $error("divisor low byte not taken");
   rx_pop_a: assert property (RX_POP_O == (rdone_w & ~RX_EMPTY_I))
      else $error("receive pop without a completed read");
   rx_data_a: assert property (rdone_w && !RX_EMPTY_I |-> AVS_READDATA_O[7:0] == RX_HEAD_I)
      else $error("receive read is not the FIFO head");
   tx_push_a: assert property (wa(`UPR_OFS_TX_DATA) && !TX_FULL_I |=> TX_PUSH_O && TX_DATA_O == $past(wb_w))
      else $error("transmit byte not pushed");
   tx_drop_a: assert property (wa(`UPR_OFS_TX_DATA) && TX_FULL_I |=> !TX_PUSH_O)
      else $error("push into a full FIFO");
   baud_limit_a: assert property (BAUD_LIMIT_ERR_O == (MODE_O[3:1] == 3'h4 && BAUD_DIVISOR_O > lim_w))
      else $error("divisor limit flag wrong");
   dmx_count_a: assert property (wa(`UPR_OFS_P1_LOW) && MODE_O == `UPR_MODE_DMX |=> DMX_COUNT_O[7:0] == $past(wb_w))
      else $error("byte count view wrong");
   dali_delay_a: assert property (wa(`UPR_OFS_P1_LOW) && MODE_O[3:1] == 3'h4 |=> DALI_DELAY_O[7:0] == $past(wb_w))
      else $error("frame delay view wrong");
   lin_pid_a: assert property (wa(`UPR_OFS_P1_LOW) && lin_w |=> LIN_PID_O == $past(wb_w[5:0]))
      else $error("identifier view wrong");
   addr_tx_a: assert property (MODE_O == `UPR_MODE_ADDR |-> ADDR_TX_O[8])
      else $error("address ninth bit clear");
   unused_view_a: assert property (MODE_O != `UPR_MODE_ADDR |-> ADDR_TX_O == 9'h000)
      else $error("address view outside address mode");
   tx_sum_a: assert property (!wa(`UPR_OFS_TX_SUM) |=> TX_SUM_O == $past(tx_nx_w))
      else $error("transmit sum wrong");
   rx_sum_a: assert property (!wa(`UPR_OFS_RX_SUM) |=> RX_SUM_O == $past(rx_nx_w))
      else $error("receive sum wrong");
endmodule // upr_checker
bind upr_top upr_checker chk_u (.*);

// ==== tb/upr_top_tb.sv ====
/*
 Self-checking bench for the parameter register block.
 Assumes the FIFO model stands in for the FIFOs; the bench drives the line events itself.
*/
`timescale 1ns/1ns
`include "upr_map.vh"
module upr_top_tb;
   logic CLOCK_I = 1'h0, RSTN_I = 1'h0, AVS_READ_I = 1'h0, AVS_WRITE_I = 1'h0;
   logic TX_SHIFT_I = 1'h0, TX_SHIFT_ID_I = 1'h0, RX_DONE_I = 1'h0, RX_DONE_ID_I = 1'h0;
   logic [7:0] AVS_ADDRESS_I = 8'h00, TX_SHIFT_BYTE_I = 8'h00, RX_DONE_BYTE_I = 8'h00;
   logic [7:0] RX_ADDR_I = 8'h00;
   logic [31:0] AVS_WRITEDATA_I = 32'h0;
   logic [3:0] AVS_BYTEENABLE_I = 4'h0;
   wire [31:0] AVS_READDATA_O;
   wire AVS_WAITREQUEST_O, RX_POP_O, TX_PUSH_O, UART_ON_O, BAUD_HIGH_SPEED_SELECT_O;
   wire CHECKSUM_SEED_OPTION_O, BAUD_LIMIT_ERR_O, ADDR_MATCH_O, RX_EMPTY_I, TX_FULL_I;
   wire [7:0] RX_HEAD_I, TX_DATA_O, LIN_TX_COUNT_O, LIN_RX_COUNT_O, TX_SUM_O, RX_SUM_O;
   wire [3:0] MODE_O;
   wire [15:0] BAUD_DIVISOR_O;
   wire [8:0] DMX_COUNT_O, DMX_FIRST_O, DMX_LAST_O, DALI_DELAY_O, DALI_THRESH_O, ADDR_TX_O;
   wire [5:0] LIN_PID_O;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] rdat;
   upr_top dut_u (.*);
   upr_fifo_model #(.DEPTH(2)) fifo_u (.clk_i(CLOCK_I), .rst_n_i(RSTN_I), .pop_i(RX_POP_O),
      .push_i(TX_PUSH_O), .push_data_i(TX_DATA_O), .head_o(RX_HEAD_I), .empty_o(RX_EMPTY_I),
      .full_o(TX_FULL_I));
   initial forever #25 CLOCK_I = ~CLOCK_I;
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, exp, input string what);
      @(negedge CLOCK_I);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Waitrequest and read data are taken at the completing rising edge;
   // a slave that never answers is left to the watchdog
   task ack;
      @(posedge CLOCK_I);
      while (AVS_WAITREQUEST_O !== 1'h0) @(posedge CLOCK_I);
      rdat = AVS_READDATA_O;
   endtask
   task wr(input logic [7:0] a, d, input logic [3:0] be = 4'h1);
      @(posedge CLOCK_I);
      AVS_ADDRESS_I <= a;
      AVS_WRITEDATA_I <= {24'h0, d};
      AVS_BYTEENABLE_I <= be;
      AVS_WRITE_I <= 1'h1;
      ack;
      AVS_WRITE_I <= 1'h0;
      // Outputs fed by the write settle only after the completing edge
      @(negedge CLOCK_I);
   endtask
   task rchk(input logic [7:0] a, exp, input string what);
      @(posedge CLOCK_I);
      AVS_ADDRESS_I <= a;
      AVS_READ_I <= 1'h1;
      ack;
      AVS_READ_I <= 1'h0;
      chk(rdat, {24'h0, exp}, what);
   endtask
   task ev(input logic [7:0] b, input logic id);
      @(posedge CLOCK_I);
      {TX_SHIFT_I, RX_DONE_I, TX_SHIFT_ID_I, RX_DONE_ID_I} <= {2'h3, id, id};
      TX_SHIFT_BYTE_I <= b;
      RX_DONE_BYTE_I <= ~b;
      @(posedge CLOCK_I);
      {TX_SHIFT_I, RX_DONE_I} <= 2'h0;
      @(negedge CLOCK_I);
   endtask
   task summarize;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge CLOCK_I);
      n_mismatch++;
      $display("wrong value at %0t: watchdog", $time);
      summarize;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
      logic [7:0] msk[10] = '{8'hff, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff};
      logic [24:0] lt[5] = '{{8'h28, 16'h7ffe, 1'h0}, {8'h28, 16'h7fff, 1'h1},
         {8'h08, 16'h1fff, 1'h1}, {8'h09, 16'h1ffe, 1'h0}, {8'h0a, 16'hffff, 1'h0}};
      logic [3:0] ml[7] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
      logic [23:0] mt[3] = '{{8'h27, 8'h0f, 8'h1}, {8'h36, 8'h0f, 8'h0}, {8'h36, 8'h00, 8'h1}};
      logic [7:0] cb[3] = '{8'h55, 8'h20, 8'hc0};
      logic [7:0] te, re;
      logic [3:0] m;
      repeat (6) @(posedge CLOCK_I);
      RSTN_I <= 1'h1;
      repeat (3) @(posedge CLOCK_I);
      for (int a = 0; a <= 8'h30; a += 4) if (a != 8) rchk(a[7:0], 8'h00, "reset");
      for (int i = 0; i < 10; i++) wr(offs[i], 8'h3c + 8'h11 * i);
      for (int i = 0; i < 10; i++) rchk(offs[i], (8'h3c + 8'h11 * i) & msk[i], "rw");
      chk(BAUD_DIVISOR_O, 16'h4d3c, "divisor");
      wr(8'h00, 8'h99, 4'h0);
      wr(8'h34, 8'hff);
      rchk(8'h00, 8'h3c, "byte enable");
      rchk(8'h34, 8'h00, "unmapped");
      for (int i = 0; i < 5; i++) begin
         wr(`UPR_OFS_CONTROL, lt[i][24:17]);
         wr(8'h04, lt[i][16:9]);
         wr(8'h00, lt[i][8:1]);
         chk(BAUD_LIMIT_ERR_O, lt[i][0], "limit");
      end
      wr(8'h10, 8'h01);
      wr(8'h14, 8'h9c);
      wr(8'h18, 8'h01);
      wr(8'h1c, 8'h37);
      wr(8'h20, 8'h00);
      wr(8'h24, 8'h0f);
      for (int i = 0; i < 7; i++) begin
         m = ml[i];
         wr(`UPR_OFS_CONTROL, {4'h0, m});
         wr(8'h14, 8'h9c);
         chk(DMX_COUNT_O, m == 4'ha ? 9'h19c : 9'h0, "count");
         chk(DMX_FIRST_O, m == 4'ha ? 9'h137 : 9'h0, "first");
         chk(DMX_LAST_O, m == 4'ha ? 9'h00f : 9'h0, "last");
         chk(DALI_DELAY_O, m[3:1] == 3'h4 ? 9'h19c : 9'h0, "delay");
         chk(DALI_THRESH_O, m[3:1] == 3'h4 ? 9'h137 : 9'h0, "thresh");
         chk(LIN_PID_O, m == 4'hb || m == 4'hc ? 6'h1c : 6'h0, "pid");
         chk(LIN_TX_COUNT_O, m == 4'hb ? 8'h37 : 8'h0, "txn");
         chk(LIN_RX_COUNT_O, m == 4'hb ? 8'h0f : 8'h0, "rxn");
         chk(ADDR_TX_O, m == 4'h4 ? 9'h19c : 9'h0, "addr");
         rchk(8'h10, 8'h01, "kept");
      end
      wr(`UPR_OFS_CONTROL, 8'hb4);
      chk({UART_ON_O, BAUD_HIGH_SPEED_SELECT_O, CHECKSUM_SEED_OPTION_O, MODE_O}, 7'h74, "ctl");
      for (int i = 0; i < 3; i++) begin
         wr(8'h24, mt[i][15:8]);
         @(posedge CLOCK_I) RX_ADDR_I <= mt[i][23:16];
         @(negedge CLOCK_I) chk(ADDR_MATCH_O, mt[i][0], "match");
      end
      for (int k = 0; k < 4; k++) begin
         wr(`UPR_OFS_CONTROL, {3'h0, k[0], k[1] ? 4'hc : 4'h0});
         wr(8'h28, 8'hf0);
         wr(8'h2c, 8'h0f);
         te = 8'hf0;
         re = 8'h0f;
         for (int j = 0; j < 3; j++) begin
            ev(cb[j], j == 0);
            if (k[1] ? (k[0] || j != 0) : k[0]) begin
               te = te + cb[j];
               re = re + ~cb[j];
            end
         end
         chk(TX_SUM_O, te, "tx sum");
         rchk(8'h2c, re, "rx sum");
      end
      fifo_u.load(8'h11);
      fifo_u.load(8'h22);
      repeat (2) @(posedge CLOCK_I);
      rchk(8'h08, 8'h11, "rx head");
      rchk(8'h08, 8'h22, "rx next");
      wr(8'h0c, 8'ha1);
      wr(8'h0c, 8'hb2);
      wr(8'h0c, 8'hc3);
      chk(fifo_u.txq.size(), 2, "tx depth");
      chk(fifo_u.txq[0], 8'ha1, "tx tail");
      chk(fifo_u.txq[1], 8'hb2, "tx order");
      summarize;
   end
endmodule // upr_top_tb
